/* File: rtl/rcal_top.sv */
// calendar counts and hour alarm match for the battery-backed clock
`timescale 1ns/1ps
`include "rcal_cfg.svh"

module rcal_top (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,

  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,

  // format selection from the control register
  input  wire logic       binary_format_select_i,
  input  wire logic       hour_24_select_i,

  // time base and time-of-day side
  input  wire logic       day_rollover_i,
  input  wire logic [7:0] hour_count_i,
  input  wire logic       alarm_check_i,
  input  wire logic       sec_min_match_i,

  // results
  output logic            alarm_event_o,
  output logic      [7:0] hour_alarm_match_o,
  output logic      [7:0] weekday_count_o,
  output logic      [7:0] date_in_month_o,
  output logic      [7:0] month_count_o,
  output logic      [7:0] year_in_century_o
);

  // ==========================================================
  // register storage
  rcal_pkg::rcal_byte_t hour_alarm_match_reg;
  rcal_pkg::rcal_byte_t hour_alarm_match_next;
  rcal_pkg::rcal_byte_t weekday_count_reg;
  rcal_pkg::rcal_byte_t weekday_count_next;
  rcal_pkg::rcal_byte_t date_in_month_reg;
  rcal_pkg::rcal_byte_t date_in_month_next;
  rcal_pkg::rcal_byte_t month_count_reg;
  rcal_pkg::rcal_byte_t month_count_next;
  rcal_pkg::rcal_byte_t year_in_century_reg;
  rcal_pkg::rcal_byte_t year_in_century_next;
  rcal_pkg::rcal_byte_t rdata_reg;
  rcal_pkg::rcal_byte_t rdata_next;
  logic                 alarm_event_reg;
  logic                 alarm_event_next;

  // ==========================================================
  // address decode
  rcal_pkg::rcal_sel_t sel;
  logic                hit_halarm;
  logic                hit_weekday;
  logic                hit_date;
  logic                hit_month;
  logic                hit_year;

  assign hit_halarm  = (reg_addr_i == `RCAL_OFS_HOUR_ALARM);
  assign hit_weekday = (reg_addr_i == `RCAL_OFS_WEEKDAY);
  assign hit_date    = (reg_addr_i == `RCAL_OFS_DATE);
  assign hit_month   = (reg_addr_i == `RCAL_OFS_MONTH);
  assign hit_year    = (reg_addr_i == `RCAL_OFS_YEAR);

  // one-hot hits folded into a named select
  assign sel = hit_halarm  ? rcal_pkg::RCAL_SEL_HOUR_ALARM :
               hit_weekday ? rcal_pkg::RCAL_SEL_WEEKDAY    :
               hit_date    ? rcal_pkg::RCAL_SEL_DATE       :
               hit_month   ? rcal_pkg::RCAL_SEL_MONTH      :
               hit_year    ? rcal_pkg::RCAL_SEL_YEAR       :
                             rcal_pkg::RCAL_SEL_NONE;

  // ==========================================================
  // write strobes per register
  logic wr_halarm;
  logic wr_weekday;
  logic wr_date;
  logic wr_month;
  logic wr_year;

  // unmapped writes fall through and change nothing
  assign wr_halarm  = reg_wr_i && (sel == rcal_pkg::RCAL_SEL_HOUR_ALARM);
  assign wr_weekday = reg_wr_i && (sel == rcal_pkg::RCAL_SEL_WEEKDAY);
  assign wr_date    = reg_wr_i && (sel == rcal_pkg::RCAL_SEL_DATE);
  assign wr_month   = reg_wr_i && (sel == rcal_pkg::RCAL_SEL_MONTH);
  assign wr_year    = reg_wr_i && (sel == rcal_pkg::RCAL_SEL_YEAR);

  // ==========================================================
  // notation-dependent limits
  logic       bin_mode;
  logic [7:0] month_max;
  logic [7:0] year_max;

  // set selects binary, clear selects BCD
  assign bin_mode  = binary_format_select_i;
  assign month_max = bin_mode ? `RCAL_MONTH_MAX_BIN : `RCAL_MONTH_MAX_BCD;
  assign year_max  = bin_mode ? `RCAL_YEAR_MAX_BIN  : `RCAL_YEAR_MAX_BCD;

  // ==========================================================
  // incrementers for the date, month and year counts; weekday adds one inline
  logic [7:0] date_inc;
  logic [7:0] month_inc;
  logic [7:0] year_inc;

  rcal_fmt_inc u_date_inc (
    .binary_i (bin_mode),
    .value_i  (date_in_month_reg),
    .next_o   (date_inc)
  );

  rcal_fmt_inc u_month_inc (
    .binary_i (bin_mode),
    .value_i  (month_count_reg),
    .next_o   (month_inc)
  );

  rcal_fmt_inc u_year_inc (
    .binary_i (bin_mode),
    .value_i  (year_in_century_reg),
    .next_o   (year_inc)
  );

  // ==========================================================
  // end-of-month detection
  logic month_end;

  rcal_last_day u_last_day (
    .binary_i (bin_mode),
    .date_i   (date_in_month_reg),
    .month_i  (month_count_reg),
    .year_i   (year_in_century_reg),
    .last_o   (month_end)
  );

  // ==========================================================
  // rollover chain: date carries into month, month into year; weekday rolls alone
  logic       week_end;
  logic       year_end;
  logic       carry_month;
  logic       carry_year;
  logic [7:0] weekday_roll;
  logic [7:0] date_roll;
  logic [7:0] month_roll;
  logic [7:0] year_roll;

  // weekday ignores the notation: 1..7 reads alike in both
  assign week_end     = (weekday_count_reg >= `RCAL_WEEKDAY_MAX) ||
                        (weekday_count_reg == `RCAL_ZERO);
  assign weekday_roll = week_end ? `RCAL_FIRST
                                 : weekday_count_reg + `RCAL_FIRST;

  // date restarts at one after the month's last day
  assign carry_month  = month_end;
  assign date_roll    = carry_month ? `RCAL_FIRST : date_inc;

  // month wraps twelve to one; zero is taken as out of range too
  assign year_end     = (month_count_reg >= month_max) ||
                        (month_count_reg == `RCAL_ZERO);
  assign carry_year   = carry_month && year_end;
  assign month_roll   = !carry_month ? month_count_reg
                      : year_end     ? `RCAL_FIRST : month_inc;

  // year 99 wraps to 0, the century is not tracked
  assign year_roll    = !carry_year  ? year_in_century_reg
                      : (year_in_century_reg >= year_max) ? `RCAL_ZERO
                      : year_inc;

  // ==========================================================
  // next-state of each count; a software write wins over a
  // rollover in the same cycle, so the written value sticks
  always_comb begin
    hour_alarm_match_next = hour_alarm_match_reg;
    if (wr_halarm) begin
      hour_alarm_match_next = reg_wdata_i;
    end
  end

  // weekday: rollover or software load
  always_comb begin
    weekday_count_next = weekday_count_reg;
    if (wr_weekday) begin
      weekday_count_next = reg_wdata_i;
    end else if (day_rollover_i) begin
      weekday_count_next = weekday_roll;
    end
  end

  // date in month: rollover or software load
  always_comb begin
    date_in_month_next = date_in_month_reg;
    if (wr_date) begin
      date_in_month_next = reg_wdata_i;
    end else if (day_rollover_i) begin
      date_in_month_next = date_roll;
    end
  end

  // month: moves on a month carry or a software load
  always_comb begin
    month_count_next = month_count_reg;
    if (wr_month) begin
      month_count_next = reg_wdata_i;
    end else if (day_rollover_i) begin
      month_count_next = month_roll;
    end
  end

  // year: moves on a year carry or a software load
  always_comb begin
    year_in_century_next = year_in_century_reg;
    if (wr_year) begin
      year_in_century_next = reg_wdata_i;
    end else if (day_rollover_i) begin
      year_in_century_next = year_roll;
    end
  end

  // ==========================================================
  // hour alarm comparison
  logic [7:0] hour_mask;
  logic       hour_dont_care;
  logic       hour_equal;
  logic       hour_match;

  // 24-hour mode keeps the AM/PM bit out of the compare
  assign hour_mask      = hour_24_select_i ? `RCAL_HOUR_MASK_24
                                           : `RCAL_HOUR_MASK_12;
  assign hour_dont_care = (hour_alarm_match_reg[7:6] == `RCAL_DONT_CARE);
  assign hour_equal     = ((hour_alarm_match_reg & hour_mask) ==
                           (hour_count_i & hour_mask));
  assign hour_match     = hour_dont_care || hour_equal;

  // event needs seconds and minutes to agree as well
  assign alarm_event_next = alarm_check_i && sec_min_match_i && hour_match;

  // ==========================================================
  // read data mux, valid only the cycle after the strobe
  logic [7:0] rd_mux;

  // unmapped offsets read as zero
  always_comb begin
    case (sel)
      rcal_pkg::RCAL_SEL_HOUR_ALARM: rd_mux = hour_alarm_match_reg;
      rcal_pkg::RCAL_SEL_WEEKDAY:    rd_mux = weekday_count_reg;
      rcal_pkg::RCAL_SEL_DATE:       rd_mux = date_in_month_reg;
      rcal_pkg::RCAL_SEL_MONTH:      rd_mux = month_count_reg;
      rcal_pkg::RCAL_SEL_YEAR:       rd_mux = year_in_century_reg;
      rcal_pkg::RCAL_SEL_NONE:       rd_mux = `RCAL_ZERO;
      default:                       rd_mux = `RCAL_ZERO;
    endcase
  end

  // data returns to zero when no read is pending
  assign rdata_next = reg_rd_i ? rd_mux : `RCAL_ZERO;

  // ==========================================================
  // calendar registers, one short process per count
  // every count clears together on the clock-domain reset

  // hour alarm match value, loaded only by software
  // the hardware never changes it
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      hour_alarm_match_reg <= `RCAL_RST_VAL;
    end else begin
      hour_alarm_match_reg <= hour_alarm_match_next;
    end
  end

  // weekday count
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      weekday_count_reg <= `RCAL_RST_VAL;
    end else begin
      weekday_count_reg <= weekday_count_next;
    end
  end

  // date in month; a write in a rollover cycle wins
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      date_in_month_reg <= `RCAL_RST_VAL;
    end else begin
      date_in_month_reg <= date_in_month_next;
    end
  end

  // month count, moved by the date carry
  // or by a software load
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      month_count_reg <= `RCAL_RST_VAL;
    end else begin
      month_count_reg <= month_count_next;
    end
  end

  // year in century; the century itself is not kept
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      year_in_century_reg <= `RCAL_RST_VAL;
    end else begin
      year_in_century_reg <= year_in_century_next;
    end
  end

  // ==========================================================
  // read data and alarm pulse registers
  // read data clears between reads so a stale byte never stands
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_reg <= `RCAL_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // alarm pulse lasts one cycle per qualifying check
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      alarm_event_reg <= 1'b0;
    end else begin
      alarm_event_reg <= alarm_event_next;
    end
  end

  // ==========================================================
  // outputs, all straight from flip-flops
  assign reg_rdata_o        = rdata_reg;
  assign alarm_event_o      = alarm_event_reg;
  assign hour_alarm_match_o = hour_alarm_match_reg;
  assign weekday_count_o    = weekday_count_reg;
  assign date_in_month_o    = date_in_month_reg;
  assign month_count_o      = month_count_reg;
  assign year_in_century_o  = year_in_century_reg;

endmodule : rcal_top

/* File: include/rcal_cfg.svh */
// constants of the calendar and hour alarm block
//
// What this block does
// - hour alarm compared with current hour count
// - top two alarm bits set: always match
// - weekday stays one through seven, Sunday first
// - weekday encoding same in binary and BCD
// - date in month held as one to 31
// - month held as one to twelve
// - year held zero to 99, 2000-2099
// - date, month, year follow format selection
// - format bit set binary, clear BCD
// - hour bit set 24-hour, clear 12-hour
`ifndef RCAL_CFG_SVH
`define RCAL_CFG_SVH

// ==========================================================
// register offsets
`define RCAL_OFS_HOUR_ALARM 8'h05
`define RCAL_OFS_WEEKDAY    8'h06
`define RCAL_OFS_DATE       8'h07
`define RCAL_OFS_MONTH      8'h08
`define RCAL_OFS_YEAR       8'h09

// ==========================================================
// reset values and fixed codes
`define RCAL_RST_VAL        8'h00
`define RCAL_ZERO           8'h00
`define RCAL_FIRST          8'h01
`define RCAL_DONT_CARE      2'b11
`define RCAL_HOUR_MASK_24   8'h7f
`define RCAL_HOUR_MASK_12   8'hff

// ==========================================================
// range limits in each notation
`define RCAL_WEEKDAY_MAX    8'h07
`define RCAL_MONTH_MAX_BIN  8'h0c
`define RCAL_MONTH_MAX_BCD  8'h12
`define RCAL_YEAR_MAX_BIN   8'h63
`define RCAL_YEAR_MAX_BCD   8'h99
`define RCAL_BCD_DIGIT_MAX  4'h9
`define RCAL_BCD_DIGIT_ZERO 4'h0
`define RCAL_BCD_DIGIT_ONE  4'h1

// ==========================================================
// month lengths, binary
`define RCAL_DAYS_31        8'h1f
`define RCAL_DAYS_30        8'h1e
`define RCAL_DAYS_29        8'h1d
`define RCAL_DAYS_28        8'h1c
`define RCAL_MONTH_FEB      8'h02
`define RCAL_MONTH_APR      8'h04
`define RCAL_MONTH_JUN      8'h06
`define RCAL_MONTH_SEP      8'h09
`define RCAL_MONTH_NOV      8'h0b
`define RCAL_LEAP_BITS      2'b00

`endif

/* File: include/rcal_pkg.sv */
// types shared by the calendar block
package rcal_pkg;

  // one register byte
  typedef logic [7:0] rcal_byte_t;

  // decoded register select
  typedef enum logic [2:0] {
    RCAL_SEL_NONE,
    RCAL_SEL_HOUR_ALARM,
    RCAL_SEL_WEEKDAY,
    RCAL_SEL_DATE,
    RCAL_SEL_MONTH,
    RCAL_SEL_YEAR
  } rcal_sel_t;

endpackage : rcal_pkg

/* File: rtl/rcal_fmt_inc.sv */
// increment of one count byte in binary or BCD notation
`timescale 1ns/1ps
`include "rcal_cfg.svh"

module rcal_fmt_inc (
  // operand
  input  wire logic       binary_i,
  input  wire logic [7:0] value_i,
  // result
  output logic      [7:0] next_o
);

  // ==========================================================
  // digit carry for BCD
  logic [3:0] lo_digit;
  logic [3:0] hi_digit;
  logic       lo_carry;
  logic [7:0] bcd_next;
  logic [7:0] bin_next;

  assign lo_digit = value_i[3:0];
  assign hi_digit = value_i[7:4];
  assign lo_carry = (lo_digit >= `RCAL_BCD_DIGIT_MAX);
  assign bcd_next = lo_carry ? {hi_digit + `RCAL_BCD_DIGIT_ONE, `RCAL_BCD_DIGIT_ZERO}
                             : {hi_digit, lo_digit + `RCAL_BCD_DIGIT_ONE};
  assign bin_next = value_i + `RCAL_FIRST;
  assign next_o   = binary_i ? bin_next : bcd_next;

endmodule : rcal_fmt_inc

/* File: rtl/rcal_last_day.sv */
// last date_in_month detector, leap aware, either notation
`timescale 1ns/1ps
`include "rcal_cfg.svh"

module rcal_last_day (
  // counts as held in the registers
  input  wire logic       binary_i,
  input  wire logic [7:0] date_i,
  input  wire logic [7:0] month_i,
  input  wire logic [7:0] year_i,
  // result
  output logic            last_o
);

  // ==========================================================
  // fold each field to binary so one table serves both notations
  logic [7:0] raw   [3];
  logic [7:0] plain [3];

  assign raw[0] = date_i;
  assign raw[1] = month_i;
  assign raw[2] = year_i;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_fold
      logic [7:0] hi;
      assign hi        = {4'h0, raw[gi][7:4]};
      assign plain[gi] = binary_i ? raw[gi]
                                  : (hi << 3) + (hi << 1) + {4'h0, raw[gi][3:0]};
    end
  endgenerate

  // ==========================================================
  // month length; every year of 2000-2099 divisible by four is leap
  logic       leap;
  logic       short_month;
  logic [7:0] month_len;

  assign leap        = (plain[2][1:0] == `RCAL_LEAP_BITS);
  assign short_month = (plain[1] == `RCAL_MONTH_APR) || (plain[1] == `RCAL_MONTH_JUN) ||
                       (plain[1] == `RCAL_MONTH_SEP) || (plain[1] == `RCAL_MONTH_NOV);
  assign month_len   = (plain[1] == `RCAL_MONTH_FEB) ? (leap ? `RCAL_DAYS_29 : `RCAL_DAYS_28)
                     : short_month ? `RCAL_DAYS_30 : `RCAL_DAYS_31;
  // out-of-range dates also end the month, so the count recovers
  assign last_o      = (plain[0] >= month_len);

endmodule : rcal_last_day

/* File: verif/rcal_chk_assertions.sv */
// assertion checker for the calendar and hour alarm block ports
`timescale 1ns/1ps
`include "rcal_cfg.svh"

module rcal_chk (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_rdata_o,
  // format and time side
  input  wire logic       binary_format_select_i,
  input  wire logic       hour_24_select_i,
  input  wire logic       day_rollover_i,
  input  wire logic [7:0] hour_count_i,
  input  wire logic       alarm_check_i,
  input  wire logic       sec_min_match_i,
  // results
  input  wire logic       alarm_event_o,
  input  wire logic [7:0] hour_alarm_match_o,
  input  wire logic [7:0] weekday_count_o,
  input  wire logic [7:0] date_in_month_o,
  input  wire logic [7:0] month_count_o,
  input  wire logic [7:0] year_in_century_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================
  // helper decode; a write in the same cycle may win, so it is left out
  wire logic [7:0] hmask   = hour_24_select_i ? `RCAL_HOUR_MASK_24 : `RCAL_HOUR_MASK_12;
  wire logic [7:0] hdiff   = (hour_alarm_match_o ^ hour_count_i) & hmask;
  wire logic       alm_try = alarm_check_i && sec_min_match_i && !reg_wr_i;
  wire logic       dc      = hour_alarm_match_o[7:6] == `RCAL_DONT_CARE;
  wire logic       roll_q  = day_rollover_i && !reg_wr_i;
  wire logic       bin     = binary_format_select_i;

  // ==========================================================
  // multi-step calendar behaviour
  sequence s_week_end;
    roll_q && weekday_count_o == `RCAL_WEEKDAY_MAX;
  endsequence
  sequence s_year_end;
    roll_q && date_in_month_o == (bin ? `RCAL_DAYS_31 : 8'h31)
      && month_count_o == (bin ? `RCAL_MONTH_MAX_BIN : `RCAL_MONTH_MAX_BCD)
      && year_in_century_o == (bin ? `RCAL_YEAR_MAX_BIN : `RCAL_YEAR_MAX_BCD);
  endsequence
  sequence s_new_year;
    date_in_month_o == `RCAL_FIRST && month_count_o == `RCAL_FIRST && year_in_century_o == `RCAL_ZERO;
  endsequence

  // ==========================================================
  // alarm
  alarm_fire_a: assert property (alm_try && dc |=> alarm_event_o)
    else $error("alarm missed with dont care hour");
  alarm_hour_a: assert property (alm_try && hdiff == 8'h00 |=> alarm_event_o)
    else $error("alarm missed on equal hour");
  alarm_miss_a: assert property (alm_try && !dc && hdiff != 8'h00 |=> !alarm_event_o)
    else $error("alarm raised on unequal hour");
  alarm_quiet_a: assert property (!(alarm_check_i && sec_min_match_i) |=> !alarm_event_o)
    else $error("alarm raised without check");

  // ==========================================================
  // calendar counts
  week_wrap_a: assert property (s_week_end |=> weekday_count_o == `RCAL_FIRST)
    else $error("weekday did not wrap to one");
  week_step_a: assert property (roll_q && weekday_count_o != 8'h00 && weekday_count_o < `RCAL_WEEKDAY_MAX
    |=> weekday_count_o == $past(weekday_count_o) + 8'h01)
    else $error("weekday did not step");
  year_wrap_a: assert property (s_year_end |=> s_new_year)
    else $error("year end did not wrap");
  counts_hold_a: assert property (!day_rollover_i && !reg_wr_i |=> $stable(date_in_month_o)
    && $stable(month_count_o) && $stable(year_in_century_o))
    else $error("count moved without cause");

  // ==========================================================
  // register port
  date_write_a: assert property (reg_wr_i && reg_addr_i == `RCAL_OFS_DATE
    |=> date_in_month_o == $past(reg_wdata_i))
    else $error("date write not applied");
  month_read_a: assert property (reg_rd_i && reg_addr_i == `RCAL_OFS_MONTH
    |=> reg_rdata_o == $past(month_count_o))
    else $error("month readback wrong");
endmodule : rcal_chk

bind rcal_top rcal_chk rcal_chk_i (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .binary_format_select_i(binary_format_select_i), .hour_24_select_i(hour_24_select_i),
  .day_rollover_i(day_rollover_i), .hour_count_i(hour_count_i), .alarm_check_i(alarm_check_i),
  .sec_min_match_i(sec_min_match_i), .alarm_event_o(alarm_event_o),
  .hour_alarm_match_o(hour_alarm_match_o), .weekday_count_o(weekday_count_o),
  .date_in_month_o(date_in_month_o), .month_count_o(month_count_o), .year_in_century_o(year_in_century_o)
);

/* File: verif/tb_top.sv */
// self-checking testbench for the calendar and hour alarm block
`timescale 1ns/1ps
`include "rcal_cfg.svh"

module tb_top;
  // ==========================================================
  // stimulus and observed outputs
  logic       mclk_i                 = 1'b0;
  logic       rst_b_i                = 1'b0;
  logic [7:0] reg_addr_i             = 8'h00;
  logic [7:0] reg_wdata_i            = 8'h00;
  logic       reg_wr_i               = 1'b0;
  logic       reg_rd_i               = 1'b0;
  logic       binary_format_select_i = 1'b0;
  logic       hour_24_select_i       = 1'b0;
  logic       day_rollover_i         = 1'b0;
  logic [7:0] hour_count_i           = 8'h00;
  logic       alarm_check_i          = 1'b0;
  logic       sec_min_match_i        = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       alarm_event_o;
  logic [7:0] hour_alarm_match_o;
  logic [7:0] weekday_count_o;
  logic [7:0] date_in_month_o;
  logic [7:0] month_count_o;
  logic [7:0] year_in_century_o;
  int         fail_count             = 0;
  int         n_compared             = 0;

  // 125 MHz clock
  always #4 mclk_i = ~mclk_i;

  rcal_top rcal_top_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .binary_format_select_i(binary_format_select_i), .hour_24_select_i(hour_24_select_i),
    .day_rollover_i(day_rollover_i), .hour_count_i(hour_count_i), .alarm_check_i(alarm_check_i),
    .sec_min_match_i(sec_min_match_i), .alarm_event_o(alarm_event_o),
    .hour_alarm_match_o(hour_alarm_match_o), .weekday_count_o(weekday_count_o),
    .date_in_month_o(date_in_month_o), .month_count_o(month_count_o), .year_in_century_o(year_in_century_o)
  );

  // ==========================================================
  // compares, bus cycles and closing
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk1

  // every bus task starts at an edge so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1 chk8("readback", exp, reg_rdata_o);
  endtask : rd

  task automatic roll();
    @(posedge mclk_i);
    day_rollover_i <= 1'b1;
    @(posedge mclk_i);
    day_rollover_i <= 1'b0;
    #1;
  endtask : roll

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    for (int a = 5; a <= 9; a++) rd(a[7:0], `RCAL_RST_VAL);
  endtask : t_reset_values

  // unmapped writes must not land anywhere, unmapped reads give zero
  task automatic t_reg_access();
    logic [7:0] v [5];
    v = '{8'h23, 8'h05, 8'h17, 8'h11, 8'h42};
    for (int i = 0; i < 5; i++) wr(8'h05 + i[7:0], v[i]);
    wr(8'h0a, 8'hff);
    wr(8'h04, 8'hee);
    for (int i = 0; i < 5; i++) rd(8'h05 + i[7:0], v[i]);
    rd(8'h0a, 8'h00);
    rd(8'h04, 8'h00);
  endtask : t_reg_access

  task automatic cal(input logic f, input logic [7:0] d, m, y, ed, em, ey);
    @(posedge mclk_i);
    binary_format_select_i <= f;
    wr(`RCAL_OFS_DATE, d);
    wr(`RCAL_OFS_MONTH, m);
    wr(`RCAL_OFS_YEAR, y);
    roll();
    chk8("date", ed, date_in_month_o);
    chk8("month", em, month_count_o);
    chk8("year", ey, year_in_century_o);
  endtask : cal

  task automatic t_calendar();
    cal(0, 8'h28, 8'h02, 8'h01, 8'h01, 8'h03, 8'h01);
    cal(0, 8'h28, 8'h02, 8'h12, 8'h29, 8'h02, 8'h12);
    cal(0, 8'h30, 8'h04, 8'h24, 8'h01, 8'h05, 8'h24);
    cal(0, 8'h09, 8'h01, 8'h00, 8'h10, 8'h01, 8'h00);
    cal(1, 8'h09, 8'h01, 8'h00, 8'h0a, 8'h01, 8'h00);
    cal(1, 8'h1c, 8'h02, 8'h08, 8'h1d, 8'h02, 8'h08);
    cal(0, 8'h31, 8'h12, 8'h19, 8'h01, 8'h01, 8'h20);
    cal(1, 8'h1f, 8'h0c, 8'h13, 8'h01, 8'h01, 8'h14);
    cal(0, 8'h31, 8'h12, 8'h99, 8'h01, 8'h01, 8'h00);
    cal(1, 8'h1f, 8'h0c, 8'h63, 8'h01, 8'h01, 8'h00);
  endtask : t_calendar

  // weekday wraps and steps the same way in both notations
  task automatic t_weekday();
    for (int f = 0; f < 2; f++) begin
      @(posedge mclk_i);
      binary_format_select_i <= f[0];
      wr(`RCAL_OFS_WEEKDAY, 8'h07);
      roll();
      chk8("weekday wrap", 8'h01, weekday_count_o);
      roll();
      chk8("weekday step", 8'h02, weekday_count_o);
    end
  endtask : t_weekday

  task automatic alm(input logic h24, input logic [7:0] av, hr, input logic smm, exp);
    @(posedge mclk_i);
    hour_24_select_i <= h24;
    wr(`RCAL_OFS_HOUR_ALARM, av);
    @(posedge mclk_i);
    hour_count_i    <= hr;
    sec_min_match_i <= smm;
    alarm_check_i   <= 1'b1;
    @(posedge mclk_i);
    alarm_check_i   <= 1'b0;
    #1 chk1("alarm pulse", exp, alarm_event_o);
    chk8("alarm value", av, hour_alarm_match_o);
    @(posedge mclk_i);
    #1 chk1("alarm end", 1'b0, alarm_event_o);
  endtask : alm

  task automatic t_alarm();
    alm(1, 8'hc0, 8'h07, 1, 1);
    alm(0, 8'hd5, 8'h85, 1, 1);
    alm(1, 8'h15, 8'h15, 1, 1);
    alm(1, 8'h15, 8'h95, 1, 1);
    alm(0, 8'h85, 8'h05, 1, 0);
    alm(1, 8'h15, 8'h16, 1, 0);
    alm(1, 8'h15, 8'h15, 0, 0);
  endtask : t_alarm

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_reset_values();
    t_reg_access();
    t_calendar();
    t_weekday();
    t_alarm();
    test_done();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_i);
    fail_count++;
    $display("[FAIL] watchdog expected done seen timeout");
    test_done();
  end
endmodule : tb_top
